/* core/cal_defs.vh */
// constants of the converter alert logic
`ifndef CAL_DEFS_VH
`define CAL_DEFS_VH

// register offsets on the device register port
`define CAL_STATUS_ADDR 8'h09
`define CAL_FLAGS_ADDR 8'h0a
`define CAL_MASKS_ADDR 8'h0b

// event_flags bit positions
`define CAL_EV_PG_RISE 0
`define CAL_EV_OTP_EXIT 1
`define CAL_EV_OTW_EXIT 2
`define CAL_EV_UV 3
`define CAL_EV_OC_EXIT 4
`define CAL_EV_OC_ENTRY 5
`define CAL_EV_OTW_ENTRY 6
`define CAL_EV_OTP_ENTRY 7

// alert_masks bit positions
`define CAL_MSK_PG 0
`define CAL_MSK_UV 1
`define CAL_MSK_OC 2
`define CAL_MSK_OTW 3
`define CAL_MSK_OTP 4
`define CAL_MSK_USED 8'h1f

// status bit positions (live, not latched)
`define CAL_ST_CC 4
`define CAL_ST_OTW 5
`define CAL_ST_OTP 6
`define CAL_ST_PG 7

// reset values and the release code
`define CAL_FLAGS_RST 8'h00
`define CAL_MASKS_RST 8'h00
`define CAL_RELEASE_ALL 8'hff

// condition inputs watched for edges
`define CAL_NCOND 5
`define CAL_C_OTP 0
`define CAL_C_OTW 1
`define CAL_C_OC 2
`define CAL_C_UV 3
`define CAL_C_PG 4

`endif

/* core/cal_edge_det.v */
// per-condition rising and falling edge detector
`timescale 1ns/1ns
module cal_edge_det #(
	parameter N = 5
) (
	clk_sys,
	rstn,
	level,
	rise,
	fall
);
	input wire clk_sys;
	input wire rstn;
	input wire [N-1:0] level;
	output wire [N-1:0] rise;
	output wire [N-1:0] fall;

	genvar i;
	generate
		for (i = 0; i < N; i = i + 1) begin : g_edge
			reg prev_r;
			// prev resets low, so a condition already true at release
			// reports as an entry event
			always @(posedge clk_sys) begin
				if (!rstn) begin
					prev_r <= 1'b0;
				end else begin
					prev_r <= level[i];
				end
			end
			assign rise[i] = level[i] & ~prev_r;
			assign fall[i] = ~level[i] & prev_r;
		end
	endgenerate
endmodule // cal_edge_det

/* core/cal_event_latch.v */
// sticky event bits, set wins over clear
`timescale 1ns/1ns
module cal_event_latch #(
	parameter N = 8
) (
	clk_sys,
	rstn,
	set_evt,
	clr_bits,
	flags
);
	input wire clk_sys;
	input wire rstn;
	input wire [N-1:0] set_evt;
	input wire [N-1:0] clr_bits;
	output wire [N-1:0] flags;

	genvar i;
	generate
		for (i = 0; i < N; i = i + 1) begin : g_bit
			reg flag_r;
			always @(posedge clk_sys) begin
				if (!rstn) begin
					flag_r <= 1'b0;
				end else if (set_evt[i]) begin
					// an event in the clearing cycle is kept
					flag_r <= 1'b1;
				end else if (clr_bits[i]) begin
					flag_r <= 1'b0;
				end
			end
			assign flags[i] = flag_r;
		end
	endgenerate
endmodule // cal_event_latch

/* core/cal_alert.v */
// alert and interrupt logic: event flags, masks, status, alert pin
`timescale 1ns/1ns
`include "cal_defs.vh"

// How it works
// [R1] thermal shutdown entry sets its event bit
// [R2] shutdown mask blocks only the alert, the event bit still records
// [R3] warning entry above the warning threshold sets its event bit
// [R4] warning mask blocks only the alert, warning bits still record
// [R5] overcurrent mask gates alert for both entry and exit events
// [R6] leaving a hiccup cycle raises no overcurrent event
// [R7] undervoltage protection entry sets event bit 3
// [R8] shutdown mask also gates the undervoltage bit's alert
// [R9] warning exit below recovery threshold sets its bit, mask gates alert only
// [R10] power good rising edge sets event bit 0
// [R11] mask bit 4 is the shutdown mask, reset 0
// [R12] mask bit 3 is the warning mask, reset 0
// [R13] mask bit 2 is the overcurrent mask, reset 0
// [R14] mask bit 1 is the undervoltage mask, reset 0
// [R15] mask bit 0 is the power good mask, reset 0
// [R16] alert is active low; writing all ones at 0x0a releases it
// [R17] status bits show present conditions, never latched
// [R18] every unmasked event asserts alert until the host clears it
// [R19] event bits stay set until the host clears them by write
module cal_alert (
	clk_sys,
	rstn,
	thermal_shutdown,
	temp_warning,
	cc_mode,
	hiccup_active,
	undervoltage,
	power_good,
	reg_addr,
	reg_wdata,
	reg_wr,
	reg_rd,
	reg_rdata,
	alert_n_pin
);
	input wire clk_sys;
	input wire rstn;
	// live condition levels from the analog side
	input wire thermal_shutdown;
	input wire temp_warning;
	input wire cc_mode;
	input wire hiccup_active;
	input wire undervoltage;
	input wire power_good;
	// register port from the serial bus front end
	input wire [7:0] reg_addr;
	input wire [7:0] reg_wdata;
	input wire reg_wr;
	input wire reg_rd;
	output reg [7:0] reg_rdata;
	output reg alert_n_pin;

	wire [`CAL_NCOND-1:0] cond;
	wire [`CAL_NCOND-1:0] rise;
	wire [`CAL_NCOND-1:0] fall;
	wire [7:0] set_evt;
	wire [7:0] clr_bits;
	wire [7:0] event_flags;
	wire [7:0] alert_en;
	wire [7:0] status;
	wire wr_flags;
	wire wr_masks;
	wire alert_any;
	wire oc_quiet;
	reg [7:0] alert_masks_r;
	reg [7:0] alert_masks_nxt;
	reg hiccup_r;
	reg [7:0] rdata_nxt;

	assign cond[`CAL_C_OTP] = thermal_shutdown;
	assign cond[`CAL_C_OTW] = temp_warning;
	assign cond[`CAL_C_OC] = cc_mode;
	assign cond[`CAL_C_UV] = undervoltage;
	assign cond[`CAL_C_PG] = power_good;

	cal_edge_det #(
		.N(`CAL_NCOND)
	) u_edge (
		.clk_sys(clk_sys),
		.rstn(rstn),
		.level(cond),
		.rise(rise),
		.fall(fall)
	);

	// the converter drops in and out of current limit while it restarts
	// from hiccup, so edges during and one cycle after it are ignored
	always @(posedge clk_sys) begin
		if (!rstn) begin
			hiccup_r <= 1'b0;
		end else begin
			hiccup_r <= hiccup_active;
		end
	end
	assign oc_quiet = hiccup_active | hiccup_r; // R6

	assign set_evt[`CAL_EV_OTP_ENTRY] = rise[`CAL_C_OTP]; // R1
	assign set_evt[`CAL_EV_OTP_EXIT] = fall[`CAL_C_OTP];
	assign set_evt[`CAL_EV_OTW_ENTRY] = rise[`CAL_C_OTW]; // R3
	assign set_evt[`CAL_EV_OTW_EXIT] = fall[`CAL_C_OTW]; // R9
	assign set_evt[`CAL_EV_OC_ENTRY] = rise[`CAL_C_OC] & ~oc_quiet; // R6
	assign set_evt[`CAL_EV_OC_EXIT] = fall[`CAL_C_OC] & ~oc_quiet; // R6
	assign set_evt[`CAL_EV_UV] = rise[`CAL_C_UV]; // R7
	assign set_evt[`CAL_EV_PG_RISE] = rise[`CAL_C_PG]; // R10

	assign wr_flags = reg_wr & (reg_addr == `CAL_FLAGS_ADDR);
	assign wr_masks = reg_wr & (reg_addr == `CAL_MASKS_ADDR);

	// ones clear their bits; all ones clears everything and frees alert
	assign clr_bits = wr_flags ? reg_wdata : 8'h00; // R16 R19

	cal_event_latch #(
		.N(8)
	) u_flags (
		.clk_sys(clk_sys),
		.rstn(rstn),
		.set_evt(set_evt),
		.clr_bits(clr_bits),
		.flags(event_flags)
	);

	// masks are applied to the alert only, never to the flags
	always @* begin
		alert_masks_nxt = alert_masks_r;
		if (wr_masks) begin
			alert_masks_nxt = reg_wdata & `CAL_MSK_USED; // R11 R12 R13 R14 R15
		end
	end

	always @(posedge clk_sys) begin
		if (!rstn) begin
			alert_masks_r <= `CAL_MASKS_RST; // R11 R12 R13 R14 R15
		end else begin
			alert_masks_r <= alert_masks_nxt;
		end
	end

	// per-flag alert enables
	assign alert_en[`CAL_EV_OTP_ENTRY] = ~alert_masks_r[`CAL_MSK_OTP]; // R2
	assign alert_en[`CAL_EV_OTP_EXIT] = ~alert_masks_r[`CAL_MSK_OTP]; // R2
	assign alert_en[`CAL_EV_OTW_ENTRY] = ~alert_masks_r[`CAL_MSK_OTW]; // R4
	assign alert_en[`CAL_EV_OTW_EXIT] = ~alert_masks_r[`CAL_MSK_OTW]; // R9
	assign alert_en[`CAL_EV_OC_ENTRY] = ~alert_masks_r[`CAL_MSK_OC]; // R5
	assign alert_en[`CAL_EV_OC_EXIT] = ~alert_masks_r[`CAL_MSK_OC]; // R5
	// the undervoltage alert answers to both its own and the shutdown mask
	assign alert_en[`CAL_EV_UV] = ~alert_masks_r[`CAL_MSK_UV] &
		~alert_masks_r[`CAL_MSK_OTP]; // R8 R14
	assign alert_en[`CAL_EV_PG_RISE] = ~alert_masks_r[`CAL_MSK_PG]; // R15

	assign alert_any = |(event_flags & alert_en); // R18

	// registered pin: no glitches from the mask/flag combination
	always @(posedge clk_sys) begin
		if (!rstn) begin
			alert_n_pin <= 1'b1;
		end else begin
			alert_n_pin <= ~alert_any; // R16 R18
		end
	end

	assign status[3:0] = 4'h0;
	assign status[`CAL_ST_CC] = cc_mode; // R17
	assign status[`CAL_ST_OTW] = temp_warning; // R17
	assign status[`CAL_ST_OTP] = thermal_shutdown; // R17
	assign status[`CAL_ST_PG] = power_good; // R17

	always @* begin
		rdata_nxt = reg_rdata;
		if (reg_rd) begin
			case (reg_addr)
				`CAL_STATUS_ADDR: begin
					rdata_nxt = status;
				end
				`CAL_FLAGS_ADDR: begin
					rdata_nxt = event_flags;
				end
				`CAL_MASKS_ADDR: begin
					rdata_nxt = alert_masks_r;
				end
				default: begin
					rdata_nxt = 8'h00;
				end
			endcase
		end
	end

	always @(posedge clk_sys) begin
		if (!rstn) begin
			reg_rdata <= 8'h00;
		end else begin
			reg_rdata <= rdata_nxt;
		end
	end
endmodule // cal_alert

/* tb/cal_host_model.sv */
// host model driving the register port
`timescale 1ns/1ns
module cal_host_model (
	input wire clk_sys,
	output logic [7:0] reg_addr = 8'h00,
	output logic [7:0] reg_wdata = 8'h00,
	output logic reg_wr = 1'b0,
	output logic reg_rd = 1'b0,
	input wire [7:0] reg_rdata
);
	// idle address and data are inverted so stale values never match
	task acc(input logic w, input logic [7:0] a, input logic [7:0] d,
		output logic [7:0] q);
		@(negedge clk_sys);
		reg_wr = w;
		reg_rd = !w;
		reg_addr = a;
		reg_wdata = d;
		@(negedge clk_sys);
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = ~a;
		reg_wdata = ~d;
		q = reg_rdata;
	endtask
endmodule // cal_host_model

/* tb/cal_alert_chk.sv */
// assertions on the alert logic ports
`timescale 1ns/1ns
module cal_chk (
	input wire clk_sys,
	input wire rstn,
	input wire thermal_shutdown,
	input wire temp_warning,
	input wire cc_mode,
	input wire hiccup_active,
	input wire undervoltage,
	input wire power_good,
	input wire [7:0] reg_addr,
	input wire [7:0] reg_wdata,
	input wire reg_wr,
	input wire alert_n_pin
);
	logic [4:0] m_r;
	wire [5:0] c = {thermal_shutdown, temp_warning, cc_mode, hiccup_active,
		undervoltage, power_good};
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rstn);
	sequence q;
		!reg_wr [*3];
	endsequence
	// mask shadow, the real one is not visible at the ports
	always @(posedge clk_sys) begin
		if (!rstn)
			m_r <= 5'h00;
		else if (reg_wr && reg_addr == 8'h0b)
			m_r <= reg_wdata[4:0];
	end
	AST_OTP: assert property (
		$rose(thermal_shutdown) && !m_r[4] ##0 q |-> ##[0:1] !alert_n_pin)
		else $error("no alert on shutdown");
	AST_OTW: assert property (
		$rose(temp_warning) && !m_r[3] ##0 q |-> ##[0:1] !alert_n_pin)
		else $error("no alert on warning");
	AST_OTWX: assert property (
		$fell(temp_warning) && !m_r[3] ##0 q |-> ##[0:1] !alert_n_pin)
		else $error("no alert on warning exit");
	AST_OC: assert property (
		$changed(cc_mode) && !hiccup_active && !$past(hiccup_active) &&
		!$past(hiccup_active, 2) && !m_r[2] ##0 q |-> ##[0:1] !alert_n_pin)
		else $error("no alert on overcurrent");
	AST_UV: assert property (
		$rose(undervoltage) && !m_r[1] && !m_r[4] ##0 q
		|-> ##[0:1] !alert_n_pin)
		else $error("no alert on undervoltage");
	AST_PG: assert property (
		$rose(power_good) && !m_r[0] ##0 q |-> ##[0:1] !alert_n_pin)
		else $error("no alert on power good");
	AST_REL: assert property (
		reg_wr && reg_addr == 8'h0a && reg_wdata == 8'hff && $stable(c)
		##1 $stable(c) |-> ##1 alert_n_pin)
		else $error("alert not released");
	AST_HOLD: assert property (
		!alert_n_pin && !reg_wr && !$past(reg_wr) |=> !alert_n_pin)
		else $error("alert dropped by itself");
endmodule // cal_chk
bind cal_alert cal_chk u_chk (.*);

/* tb/cal_alert_bench.sv */
// bench for the alert logic
`timescale 1ns/1ns
module cal_alert_bench;
	logic clk_sys = 1'b0;
	logic rstn = 1'b0;
	logic [5:0] c = 6'h00;
	logic [7:0] reg_addr, reg_wdata, reg_rdata;
	logic reg_wr, reg_rd, alert_n_pin;
	int num_errors = 0;
	int comparisons = 0;
	always #50 clk_sys = ~clk_sys;
	cal_alert u_dut (.clk_sys(clk_sys), .rstn(rstn),
		.thermal_shutdown(c[5]), .temp_warning(c[4]), .cc_mode(c[3]),
		.hiccup_active(c[2]), .undervoltage(c[1]), .power_good(c[0]),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata), .alert_n_pin(alert_n_pin));
	cal_host_model u_host (.clk_sys(clk_sys), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata));
	task cmp(input string n, input logic [7:0] e, input logic [7:0] s);
		comparisons++;
		if (s !== e) begin
			num_errors++;
			$display("[FAIL] %s expected %h seen %h", n, e, s);
		end
	endtask
	task rdc(input string n, input logic [7:0] a, input logic [7:0] e);
		logic [7:0] v;
		u_host.acc(1'b0, a, 8'h00, v);
		cmp(n, e, v);
	endtask
	task wr(input logic [7:0] a, input logic [7:0] d);
		logic [7:0] v;
		u_host.acc(1'b1, a, d, v);
		@(negedge clk_sys);
	endtask
	// two cycles of event latency plus margin
	task cond(input logic [5:0] v);
		@(negedge clk_sys);
		c = v;
		repeat (3) @(negedge clk_sys);
	endtask
	task alert(input logic e);
		cmp("alert", {7'h00, e}, {7'h00, alert_n_pin});
	endtask
	task t_thermal;
		alert(1'b1);
		rdc("masks", 8'h0b, 8'h00);
		cond(6'h20);
		alert(1'b0);
		rdc("flags", 8'h0a, 8'h80);
		rdc("unmapped", 8'h3c, 8'h00);
		rdc("status", 8'h09, 8'h40);
		cond(6'h00);
		rdc("flags", 8'h0a, 8'h82);
		rdc("status", 8'h09, 8'h00);
		wr(8'h0a, 8'hff);
		alert(1'b1);
		$display("thermal test done");
	endtask
	task t_all(input logic [7:0] m);
		wr(8'h0b, m);
		cond(6'h3b);
		rdc("status", 8'h09, 8'hf0);
		cond(6'h00);
		alert(m != 8'h00);
		rdc("flags", 8'h0a, 8'hff);
		rdc("masks", 8'h0b, m & 8'h1f);
		wr(8'h0b, 8'h00);
		alert(1'b0);
		wr(8'h0a, 8'hff);
		alert(1'b1);
		$display("event test done");
	endtask
	// one source at a time against one mask pattern
	task t_one(input logic [7:0] m, input logic [5:0] v,
		input logic [7:0] f, input logic e);
		wr(8'h0b, m);
		cond(v);
		cond(6'h00);
		rdc("flags", 8'h0a, f);
		alert(e);
		wr(8'h0a, 8'hff);
		wr(8'h0b, 8'h00);
		alert(1'b1);
	endtask
	task t_masks;
		t_one(8'h10, 6'h20, 8'h82, 1'b1);
		t_one(8'h0f, 6'h20, 8'h82, 1'b0);
		t_one(8'h08, 6'h10, 8'h44, 1'b1);
		t_one(8'h17, 6'h10, 8'h44, 1'b0);
		t_one(8'h04, 6'h08, 8'h30, 1'b1);
		t_one(8'h1b, 6'h08, 8'h30, 1'b0);
		t_one(8'h10, 6'h02, 8'h08, 1'b1);
		t_one(8'h02, 6'h02, 8'h08, 1'b1);
		t_one(8'h0d, 6'h02, 8'h08, 1'b0);
		t_one(8'h01, 6'h01, 8'h01, 1'b1);
		t_one(8'h1e, 6'h01, 8'h01, 1'b0);
		$display("mask test done");
	endtask
	task t_hiccup;
		cond(6'h04);
		cond(6'h0c);
		cond(6'h00);
		rdc("flags", 8'h0a, 8'h00);
		alert(1'b1);
		$display("hiccup test done");
	endtask
	task end_sim;
		$display("errors %0d comparisons %0d", num_errors, comparisons);
		if (num_errors == 0 && comparisons > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	initial begin
		repeat (16) @(negedge clk_sys);
		rstn = 1'b1;
		t_thermal;
		t_all(8'h00);
		t_all(8'hff);
		t_masks;
		t_hiccup;
		end_sim;
	end
endmodule // cal_alert_bench
